/* rtl/adcr_pkg.sv */
package adcr_pkg;
	localparam logic [7:0] ADDR_PEDESTAL = 8'h3f;
	localparam logic [7:0] ADDR_LOOP = 8'hcf;
	localparam logic [7:0] ADDR_MODE = 8'hdf;
	localparam logic [7:0] ADDR_SRC = 8'hea;
	localparam logic [7:0] ADDR_ENH = 8'hec;
	localparam logic [7:0] ADDR_STAT = 8'hed;
	localparam logic [7:0] RST_VAL = 8'h00;
	localparam int PED_MSB = 7;
	localparam int PED_LSB = 5;
	localparam int HOLD_BIT = 7;
	localparam int SPAN_MSB = 5;
	localparam int SPAN_LSB = 2;
	localparam int SRC_BIT = 7;
	localparam int ENH_BIT = 1;
	localparam int LS_MSB = 5;
	localparam int LS_LSB = 4;
	localparam int DCEN_BIT = 0;
	localparam logic [1:0] LS_ON = 2'h3;
	localparam logic [3:0] SPAN_MAX = 4'hb;
	localparam int SAMPLE_W = 11;
	localparam int ACC_W = 48;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} adcr_bus_s;
	typedef struct packed {
		logic [7:0] pedestal;
		logic [7:0] loop;
		logic [7:0] mode;
		logic [7:0] src;
		logic [7:0] enh;
	} adcr_regs_s;
endpackage

/* rtl/adcr_top.sv */
`timescale 1ns/1ps
module adcr_top #(
	parameter int SW = adcr_pkg::SAMPLE_W,
	parameter longint MEGA = 1048576
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire adcr_pkg::adcr_bus_s bus,
	output logic [7:0] rdata,
	input wire logic noise_shaping_pin,
	input wire logic [SW-1:0] sample_in,
	output logic [SW-1:0] sample_out,
	output logic noise_shaping_on,
	output logic low_speed_on
);
	localparam int AW = adcr_pkg::ACC_W;
	localparam logic [AW-1:0] M1 = AW'(MEGA);
	logic [1:0] pin_sync_q;
	logic [1:0] pin_sync_d;
	adcr_pkg::adcr_regs_s regs_q, regs_d;
	logic [7:0] rdata_q, rdata_d;
	logic signed [AW-1:0] acc_q, acc_d;
	logic [AW-1:0] cnt_q, cnt_d;
	logic signed [SW:0] est_q, est_d;
	logic [SW-1:0] out_q, out_d;
	logic ns_q, ns_d, ls_q, ls_d;
	logic [AW-1:0] span;
	logic [3:0] code;
	logic dc_en, hold;
	logic signed [SW+1:0] corr;
	logic signed [SW+1:0] ped;

	assign dc_en = regs_q.enh[adcr_pkg::DCEN_BIT];
	assign hold = regs_q.loop[adcr_pkg::HOLD_BIT];
	assign code = regs_q.loop[adcr_pkg::SPAN_MSB:adcr_pkg::SPAN_LSB];

	// Averaging span decode
	always_comb begin
		unique case (code)
			4'h0: span = M1;
			4'h1: span = M1 * AW'(2);
			4'h2: span = M1 * AW'(3);
			4'h3: span = M1 * AW'(4);
			default: begin
				if (code > adcr_pkg::SPAN_MAX) begin
					span = M1 << 11;
				end else begin
					span = M1 << (code);
				end
			end
		endcase
	end

	// Register file
	always_comb begin
		regs_d = regs_q;
		rdata_d = 8'h00;
		pin_sync_d = {pin_sync_q[0], noise_shaping_pin};
		if (bus.wr) begin
			unique case (bus.addr)
				adcr_pkg::ADDR_PEDESTAL: regs_d.pedestal = bus.wdata;
				adcr_pkg::ADDR_LOOP: regs_d.loop = bus.wdata;
				adcr_pkg::ADDR_MODE: regs_d.mode = bus.wdata;
				adcr_pkg::ADDR_SRC: regs_d.src = bus.wdata;
				adcr_pkg::ADDR_ENH: regs_d.enh = bus.wdata;
				default: regs_d = regs_q;
			endcase
		end
		if (bus.rd) begin
			unique case (bus.addr)
				adcr_pkg::ADDR_PEDESTAL: rdata_d = regs_q.pedestal;
				adcr_pkg::ADDR_LOOP: rdata_d = regs_q.loop;
				adcr_pkg::ADDR_MODE: rdata_d = regs_q.mode;
				adcr_pkg::ADDR_SRC: rdata_d = regs_q.src;
				adcr_pkg::ADDR_ENH: rdata_d = regs_q.enh;
				adcr_pkg::ADDR_STAT: rdata_d = {6'h00, ls_q, ns_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			regs_q <= '0;
			rdata_q <= adcr_pkg::RST_VAL;
			pin_sync_q <= 2'h0;
		end else begin
			regs_q <= regs_d;
			rdata_q <= rdata_d;
			pin_sync_q <= pin_sync_d;
		end
	end

	// Mode outputs
	always_comb begin
		if (regs_q.src[adcr_pkg::SRC_BIT]) begin
			ns_d = regs_q.enh[adcr_pkg::ENH_BIT];
		end else begin
			ns_d = pin_sync_q[1];
		end
		ls_d = (regs_q.mode[adcr_pkg::LS_MSB:adcr_pkg::LS_LSB]
			== adcr_pkg::LS_ON);
	end

	// Offset estimator
	always_comb begin
		acc_d = acc_q;
		cnt_d = cnt_q;
		est_d = est_q;
		ped = (SW+2)'(signed'(regs_q.pedestal[adcr_pkg::PED_MSB:
			adcr_pkg::PED_LSB]));
		corr = $signed({2'b00, sample_in}) - (SW+2)'(est_q) + ped;
		if (!dc_en) begin
			acc_d = '0;
			cnt_d = '0;
			est_d = '0;
		end else if (!hold) begin
			if (cnt_q + AW'(1) >= span) begin
				est_d = (SW+1)'((acc_q + AW'($signed({1'b0, sample_in}))
					- AW'(1 << (SW-1))) / $signed(span));
				acc_d = '0;
				cnt_d = '0;
			end else begin
				acc_d = acc_q + AW'($signed({1'b0, sample_in}))
					- AW'(1 << (SW-1));
				cnt_d = cnt_q + AW'(1);
			end
		end
		if (!dc_en) begin
			out_d = sample_in;
		end else if (corr < 0) begin
			out_d = '0;
		end else if (corr > $signed({2'b00, {SW{1'b1}}})) begin
			out_d = '1;
		end else begin
			out_d = corr[SW-1:0];
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			acc_q <= '0;
			cnt_q <= '0;
			est_q <= '0;
			out_q <= '0;
			ns_q <= 1'b0;
			ls_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			cnt_q <= cnt_d;
			est_q <= est_d;
			out_q <= out_d;
			ns_q <= ns_d;
			ls_q <= ls_d;
		end
	end

	assign rdata = rdata_q;
	assign sample_out = out_q;
	assign noise_shaping_on = ns_q;
	assign low_speed_on = ls_q;

	low_speed_a: assert property (@(posedge clock) disable iff (!arst_n)
		$past(regs_q.mode[5:4]) == 2'h3 |-> low_speed_on)
		else $error("low speed not entered");
	low_speed_off_a: assert property (@(posedge clock) disable iff (!arst_n)
		$past(regs_q.mode[5:4]) != 2'h3 |-> !low_speed_on)
		else $error("low speed wrongly on");
	pin_source_a: assert property (@(posedge clock) disable iff (!arst_n)
		!$past(regs_q.src[7]) |-> noise_shaping_on == $past(pin_sync_q[1]))
		else $error("pin source not followed");
	reg_source_a: assert property (@(posedge clock) disable iff (!arst_n)
		$past(regs_q.src[7]) |-> noise_shaping_on == $past(regs_q.enh[1]))
		else $error("register source not followed");
	hold_est_a: assert property (@(posedge clock) disable iff (!arst_n)
		dc_en && hold ##1 dc_en && hold |-> $stable(est_q))
		else $error("estimate moved while held");
	readback_a: assert property (@(posedge clock) disable iff (!arst_n)
		bus.wr && bus.addr == 8'hcf ##1 bus.rd && bus.addr == 8'hcf
		&& !bus.wr |=> rdata == $past(bus.wdata, 2))
		else $error("readback mismatch");
	count_run_a: assert property (@(posedge clock) disable iff (!arst_n)
		dc_en && !hold && cnt_q + 1 < span |=> cnt_q == $past(cnt_q) + 1)
		else $error("estimator stalled");
	bypass_a: assert property (@(posedge clock) disable iff (!arst_n)
		!dc_en |=> sample_out == $past(sample_in))
		else $error("bypass broken");
	low_speed_c: cover property (@(posedge clock) low_speed_on);
	reg_source_c: cover property (@(posedge clock) regs_q.src[7]
		&& noise_shaping_on);
	hold_c: cover property (@(posedge clock) dc_en && hold);
endmodule // adcr_top

/* tb/adcr_top_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
	$display("BAD %0t got %h exp %h", $time, a, b); end end
module adcr_top_bench;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	adcr_pkg::adcr_bus_s bus = '0;
	logic [7:0] rdata;
	logic noise_shaping_pin = 1'b0;
	logic [10:0] sample_in = 11'h410;
	logic [10:0] sample_out;
	logic noise_shaping_on;
	logic low_speed_on;
	int error_cnt = 0;
	int tests_run = 0;
	logic [7:0] addrs [5] = '{adcr_pkg::ADDR_PEDESTAL, adcr_pkg::ADDR_LOOP,
		adcr_pkg::ADDR_MODE, adcr_pkg::ADDR_SRC, adcr_pkg::ADDR_ENH};
	logic [7:0] vals [5] = '{8'he0, 8'hac, 8'h30, 8'h80, 8'h03};
	logic [7:0] peds [2] = '{8'h80, 8'h60};
	logic [10:0] outs [2] = '{11'h3fc, 11'h403};
	adcr_top #(.MEGA(4)) DUT (
		.clock(clock),
		.arst_n(arst_n),
		.bus(bus),
		.rdata(rdata),
		.noise_shaping_pin(noise_shaping_pin),
		.sample_in(sample_in),
		.sample_out(sample_out),
		.noise_shaping_on(noise_shaping_on),
		.low_speed_on(low_speed_on)
	);
	initial begin
		forever #50 clock = ~clock;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask
	task automatic print_verdict;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#5000000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		foreach (addrs[i]) rd(addrs[i], 8'h00);
		foreach (addrs[i]) wr(addrs[i], vals[i]);
		foreach (addrs[i]) rd(addrs[i], vals[i]);
		// Write then read with no gap
		@(posedge clock) bus <= '{addr: adcr_pkg::ADDR_LOOP, wdata: 8'h24,
			wr: 1'b1, rd: 1'b0};
		@(posedge clock) bus <= '{addr: adcr_pkg::ADDR_LOOP, wdata: 8'h00,
			wr: 1'b0, rd: 1'b1};
		@(posedge clock) bus.rd <= 1'b0;
		#1 `CHK(rdata, 8'h24)
		wr(8'h01, 8'h5a);
		rd(8'h01, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(adcr_pkg::ADDR_MODE, 8'(i << 4));
			repeat (2) @(posedge clock);
			#1 `CHK(low_speed_on, (i == 3))
		end
		wr(adcr_pkg::ADDR_SRC, 8'h00);
		wr(adcr_pkg::ADDR_ENH, 8'h00);
		@(posedge clock) noise_shaping_pin <= 1'b1;
		repeat (5) @(posedge clock);
		#1 `CHK(noise_shaping_on, 1'b1)
		wr(adcr_pkg::ADDR_SRC, 8'h80);
		repeat (3) @(posedge clock);
		#1 `CHK(noise_shaping_on, 1'b0)
		wr(adcr_pkg::ADDR_ENH, 8'h02);
		@(posedge clock) noise_shaping_pin <= 1'b0;
		repeat (5) @(posedge clock);
		#1 `CHK(noise_shaping_on, 1'b1)
		rd(adcr_pkg::ADDR_STAT, 8'h03);
		for (int i = 0; i < 2; i++) begin
			wr(adcr_pkg::ADDR_PEDESTAL, peds[i]);
			wr(adcr_pkg::ADDR_ENH, 8'h01);
			wr(adcr_pkg::ADDR_LOOP, 8'h00);
			repeat (40) @(posedge clock);
			#1 `CHK(sample_out, outs[i])
			wr(adcr_pkg::ADDR_LOOP, 8'h80);
			@(posedge clock) sample_in <= 11'h420;
			repeat (10) @(posedge clock);
			#1 `CHK(sample_out, outs[i] + 11'h010)
			wr(adcr_pkg::ADDR_LOOP, 8'h00);
			repeat (40) @(posedge clock);
			#1 `CHK(sample_out, outs[i])
			@(posedge clock) sample_in <= 11'h410;
		end
		print_verdict();
	end
endmodule // adcr_top_bench
